// file: hbsv_bus_chk.sv
`timescale 1ns/1ns
// --------------------------------------------
// Checker of both bus variants.
// --------------------------------------------
module hbsv_bus_chk (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic rd_wr_n,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic ack_chip_select_n,
  input wire logic fixed_chip_select_n,
  input wire logic output_enable_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic port_size_ack_n,
  input wire logic port_size_ack_oe
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence ack_low_s;
    port_size_ack_oe && !port_size_ack_n;
  endsequence
  sequence ack_end_s;
    port_size_ack_oe && port_size_ack_n ##1 !port_size_ack_oe;
  endsequence
  AST_ACK_DRIVE: assert property ($fell(addr_strobe_n) && !ack_chip_select_n |-> ##[0:2] port_size_ack_oe)
    else $error("ack not driven");
  AST_ACK_END: assert property ($rose(addr_strobe_n) |-> ##[0:2] ack_end_s)
    else $error("ack not ended");
  AST_RD_DRIVE: assert property ($fell(data_strobe_n) && rd_wr_n |-> ##[0:3] dev_data_oe)
    else $error("read data not driven");
  AST_RD_VALID: assert property (rd_wr_n && !data_strobe_n ##0 ack_low_s |-> dev_data_oe)
    else $error("ack without data");
  AST_RD_FREE: assert property ($rose(data_strobe_n) |-> ##[0:2] !dev_data_oe)
    else $error("data bus held");
  AST_DS_HOLD: assert property ($rose(data_strobe_n) |-> $past(port_size_ack_n) == 1'b0)
    else $error("strobe left early");
  AST_DS_AS: assert property (!data_strobe_n |-> !addr_strobe_n)
    else $error("strobe order");
  AST_GAP: assert property ($rose(addr_strobe_n) |=> addr_strobe_n)
    else $error("no idle gap");
  AST_WDATA: assert property (!data_strobe_n && !rd_wr_n |-> host_data_oe)
    else $error("write data missing");
  AST_FIX_FREE: assert property ($rose(output_enable_n) |-> ##[0:2] !dev_data_oe)
    else $error("fixed bus held");
  AST_FIX_LEN: assert property ($fell(fixed_chip_select_n) |-> (!fixed_chip_select_n) [*8] ##1 !fixed_chip_select_n
    ##1 !fixed_chip_select_n ##1 fixed_chip_select_n)
    else $error("cycle length");
  AST_ONE_VAR: assert property (!fixed_chip_select_n |-> !port_size_ack_oe)
    else $error("ack in fixed");
endmodule : hbsv_bus_chk

// file: hbsv_bus_if.sv
`timescale 1ns/1ns
interface hbsv_bus_if;
  logic [16:0] addr;
  logic rd_wr_n;
  logic [1:0] transfer_size;
  logic addr_strobe_n;
  logic data_strobe_n;
  logic ack_chip_select_n;
  logic upper_strobe_n;
  logic lower_strobe_n;
  logic fixed_chip_select_n;
  logic low_byte_enable_n;
  logic high_byte_enable_n;
  logic output_enable_n;
  logic [15:0] host_data;
  logic host_data_oe;
  logic [15:0] dev_data;
  logic dev_data_oe;
  logic port_size_ack_n;
  logic port_size_ack_oe;
  modport device (
    input addr, rd_wr_n, transfer_size, addr_strobe_n, data_strobe_n, ack_chip_select_n,
    input upper_strobe_n, lower_strobe_n, fixed_chip_select_n, low_byte_enable_n,
    input high_byte_enable_n, output_enable_n, host_data, host_data_oe,
    output dev_data, dev_data_oe, port_size_ack_n, port_size_ack_oe
  );
  modport host (
    output addr, rd_wr_n, transfer_size, addr_strobe_n, data_strobe_n, ack_chip_select_n,
    output upper_strobe_n, lower_strobe_n, fixed_chip_select_n, low_byte_enable_n,
    output high_byte_enable_n, output_enable_n, host_data, host_data_oe,
    input dev_data, dev_data_oe, port_size_ack_n, port_size_ack_oe
  );
endinterface : hbsv_bus_if

// file: hbsv_device.sv
`timescale 1ns/1ns
module hbsv_device
  import hbsv_pkg::*;
#(
  parameter int ADDR_W = HBSV_ADDR_W,
  parameter int DATA_W = HBSV_DATA_W
)
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic variant_sel_in,
  input wire logic [1:0] mclk_div_in,
  hbsv_bus_if.device bus,
  output logic wr_valid_out,
  output logic [16:0] wr_addr_out,
  output logic [15:0] wr_data_out,
  output logic [1:0] wr_be_out,
  output logic rd_req_out,
  output logic [16:0] rd_addr_out,
  input wire logic [15:0] rd_data_in,
  output logic blt_enable_out
);
  // ------------------------------------------------------------
  // Variant latch and cycle tracking.
  // ------------------------------------------------------------
  typedef enum logic [2:0] {HBSV_IDLE = 3'b001, HBSV_BUSY = 3'b010, HBSV_DONE = 3'b100} hbsv_state_e;
  hbsv_state_e st_r, st_nxt;
  logic variant_r, variant_nxt, strap_done_r, strap_done_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic ack_n_r, ack_n_nxt, ack_oe_r, ack_oe_nxt;
  logic wr_v_r, wr_v_nxt, rd_q_r, rd_q_nxt;
  logic [15:0] wdat_r, wdat_nxt;
  logic [1:0] be_r, be_nxt;
  logic [16:0] adr_r, adr_nxt;
  logic [3:0] rd_lat, rd_pt;
  logic ack_sel, ack_ds, fix_sel, fix_rd, is_rd;
  // ------------------------------------------------------------
  // Width checks.
  // ------------------------------------------------------------
  if (ADDR_W != HBSV_ADDR_W || DATA_W != HBSV_DATA_W)
  begin : g_bad_width
    $error("Bus widths must match the interface.");
  end
  // ------------------------------------------------------------
  // Fixed variant read timing.
  // ------------------------------------------------------------
  always_comb
  begin
    case (mclk_div_in)
      2'h0: rd_lat = HBSV_RD_LAT_DIV1;
      2'h1: rd_lat = HBSV_RD_LAT_DIV2;
      2'h2: rd_lat = HBSV_RD_LAT_DIV3;
      default: rd_lat = HBSV_RD_LAT_DIV4;
    endcase
  end
  // Latencies past the fixed cycle load data one edge before it ends.
  assign rd_pt = (rd_lat < HBSV_FIXED_LEN) ? rd_lat - 4'h1 : HBSV_FIXED_LEN - 4'h2; // [R10]
  // ------------------------------------------------------------
  // Strobe decode.
  // ------------------------------------------------------------
  // Strobes of the inactive variant are masked off. [R14]
  assign ack_sel = (variant_r == HBSV_VARIANT_ACK) && strap_done_r && !bus.ack_chip_select_n && !bus.addr_strobe_n;
  assign ack_ds = ack_sel && !bus.data_strobe_n;
  assign fix_sel = (variant_r == HBSV_VARIANT_FIXED) && strap_done_r && !bus.fixed_chip_select_n
                   && (!bus.low_byte_enable_n || !bus.high_byte_enable_n);
  assign fix_rd = fix_sel && !bus.output_enable_n;
  assign is_rd = (variant_r == HBSV_VARIANT_ACK) ? bus.rd_wr_n : !bus.output_enable_n;
  // The block-transfer path is disabled in the fixed variant. [R13]
  assign blt_enable_out = strap_done_r && (variant_r == HBSV_VARIANT_ACK);
  // ------------------------------------------------------------
  // Next state.
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    variant_nxt = variant_r;
    strap_done_nxt = 1'b1;
    cnt_nxt = cnt_r;
    rdat_nxt = rdat_r;
    ack_n_nxt = ack_n_r;
    ack_oe_nxt = ack_oe_r;
    wr_v_nxt = 1'b0;
    rd_q_nxt = 1'b0;
    wdat_nxt = wdat_r;
    be_nxt = be_r;
    adr_nxt = adr_r;
    if (!strap_done_r)
    begin
      variant_nxt = variant_sel_in; // [R14]
    end
    case (st_r)
      HBSV_IDLE:
      begin
        cnt_nxt = 4'h1;
        if (ack_sel || fix_sel)
        begin
          st_nxt = HBSV_BUSY;
          adr_nxt = bus.addr;
          be_nxt = (variant_r == HBSV_VARIANT_ACK) ? {!bus.upper_strobe_n, !bus.lower_strobe_n}
                                                   : {!bus.high_byte_enable_n, !bus.low_byte_enable_n};
          rd_q_nxt = is_rd;
          ack_oe_nxt = ack_sel; // [R1]
          ack_n_nxt = 1'b1;
        end
      end
      HBSV_BUSY:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == HBSV_WR_EDGE - 4'h1 && !is_rd)
        begin
          wdat_nxt = bus.host_data; // [R9] [R8]
          wr_v_nxt = 1'b1;
        end
        // The ack variant loads memory data the edge after the request pulse.
        if (cnt_r == 4'h1 && is_rd && variant_r == HBSV_VARIANT_ACK)
        begin
          rdat_nxt = rd_data_in;
        end
        if (variant_r == HBSV_VARIANT_ACK)
        begin
          if (cnt_r >= HBSV_ACK_DELAY && !bus.data_strobe_n)
          begin
            ack_n_nxt = 1'b0; // [R4] [R6]
          end
          if (bus.addr_strobe_n || bus.ack_chip_select_n)
          begin
            ack_n_nxt = 1'b1; // [R2]
            st_nxt = HBSV_DONE;
          end
        end
        else
        begin
          if (cnt_r == rd_pt && is_rd)
          begin
            rdat_nxt = rd_data_in; // [R10]
          end
          if (cnt_r == HBSV_FIXED_LEN - 4'h1)
          begin
            st_nxt = HBSV_DONE; // [R12]
          end
        end
      end
      HBSV_DONE:
      begin
        ack_oe_nxt = 1'b0; // [R2]
        ack_n_nxt = 1'b1;
        if (!ack_sel && !fix_sel)
        begin
          st_nxt = HBSV_IDLE; // [R7]
        end
      end
      default:
      begin
        st_nxt = HBSV_IDLE;
      end
    endcase
  end
  // ------------------------------------------------------------
  // Registers.
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= HBSV_IDLE;
      variant_r <= HBSV_VARIANT_ACK;
      strap_done_r <= 1'b0;
      cnt_r <= 4'h0;
      rdat_r <= 16'h0000;
      ack_n_r <= 1'b1;
      ack_oe_r <= 1'b0;
      wr_v_r <= 1'b0;
      rd_q_r <= 1'b0;
      wdat_r <= 16'h0000;
      be_r <= 2'h0;
      adr_r <= 17'h00000;
    end
    else
    begin
      st_r <= st_nxt;
      variant_r <= variant_nxt;
      strap_done_r <= strap_done_nxt;
      cnt_r <= cnt_nxt;
      rdat_r <= rdat_nxt;
      ack_n_r <= ack_n_nxt;
      ack_oe_r <= ack_oe_nxt;
      wr_v_r <= wr_v_nxt;
      rd_q_r <= rd_q_nxt;
      wdat_r <= wdat_nxt;
      be_r <= be_nxt;
      adr_r <= adr_nxt;
    end
  end
  // ------------------------------------------------------------
  // Pin drive.
  // ------------------------------------------------------------
  assign bus.port_size_ack_n = ack_n_r;
  assign bus.port_size_ack_oe = ack_oe_r;
  assign bus.dev_data = rdat_r; // [R4]
  // Data drive follows the read strobes and drops as they rise. [R3] [R5] [R11]
  assign bus.dev_data_oe = (st_r == HBSV_BUSY) && is_rd && (ack_ds || fix_rd);
  assign wr_valid_out = wr_v_r;
  assign wr_addr_out = adr_r;
  assign wr_data_out = wdat_r;
  assign wr_be_out = be_r;
  assign rd_req_out = rd_q_r;
  assign rd_addr_out = adr_r;
endmodule : hbsv_device

// file: hbsv_host.sv
`timescale 1ns/1ns
module hbsv_host
  import hbsv_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic variant_in,
  input wire logic req_in,
  input wire logic req_rd_in,
  input wire logic [16:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic [1:0] req_be_in,
  input wire logic [3:0] req_rd_lat_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  hbsv_bus_if.host bus
);
  // ------------------------------------------------------------
  // Host cycle sequencer.
  // ------------------------------------------------------------
  typedef enum logic [2:0] {HBSV_H_IDLE = 3'b001, HBSV_H_RUN = 3'b010, HBSV_H_GAP = 3'b100} hbsv_hstate_e;
  hbsv_hstate_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt, var_r, var_nxt, sel_r, sel_nxt, ds_r, ds_nxt, done_r, done_nxt;
  logic [16:0] adr_r, adr_nxt;
  logic [15:0] wd_r, wd_nxt, rd_dat_r, rd_dat_nxt;
  logic [1:0] be_r, be_nxt;
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    var_nxt = var_r;
    sel_nxt = sel_r;
    ds_nxt = ds_r;
    done_nxt = 1'b0;
    adr_nxt = adr_r;
    wd_nxt = wd_r;
    be_nxt = be_r;
    rd_dat_nxt = rd_dat_r;
    case (st_r)
      HBSV_H_IDLE:
      begin
        if (req_in)
        begin
          st_nxt = HBSV_H_RUN;
          rd_nxt = req_rd_in;
          var_nxt = variant_in;
          adr_nxt = req_addr_in;
          wd_nxt = req_wdata_in;
          be_nxt = req_be_in;
          sel_nxt = 1'b1;
          ds_nxt = 1'b1;
          cnt_nxt = 4'h0;
        end
      end
      HBSV_H_RUN:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (var_r == HBSV_VARIANT_ACK)
        begin
          // Strobe held until the acknowledge is seen low. [R6]
          if (bus.port_size_ack_oe && !bus.port_size_ack_n)
          begin
            rd_dat_nxt = bus.dev_data;
            ds_nxt = 1'b0;
            sel_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = HBSV_H_GAP;
          end
        end
        else
        begin
          // Latencies past the cycle end are sampled at its last edge.
          if (rd_r && (cnt_r == req_rd_lat_in || (cnt_r == HBSV_FIXED_LEN - 4'h1 && req_rd_lat_in >= HBSV_FIXED_LEN)))
          begin
            rd_dat_nxt = bus.dev_data; // [R10]
          end
          if (cnt_r == HBSV_FIXED_LEN - 4'h1)
          begin
            sel_nxt = 1'b0; // [R12]
            ds_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = HBSV_H_GAP;
          end
        end
      end
      HBSV_H_GAP:
      begin
        st_nxt = HBSV_H_IDLE; // [R7]
      end
      default:
      begin
        st_nxt = HBSV_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= HBSV_H_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      var_r <= HBSV_VARIANT_ACK;
      sel_r <= 1'b0;
      ds_r <= 1'b0;
      done_r <= 1'b0;
      adr_r <= 17'h00000;
      wd_r <= 16'h0000;
      be_r <= 2'h0;
      rd_dat_r <= 16'h0000;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      var_r <= var_nxt;
      sel_r <= sel_nxt;
      ds_r <= ds_nxt;
      done_r <= done_nxt;
      adr_r <= adr_nxt;
      wd_r <= wd_nxt;
      be_r <= be_nxt;
      rd_dat_r <= rd_dat_nxt;
    end
  end
  // ------------------------------------------------------------
  // Pin drive.
  // ------------------------------------------------------------
  logic act_ack, act_fix;
  assign act_ack = sel_r && (var_r == HBSV_VARIANT_ACK);
  assign act_fix = sel_r && (var_r == HBSV_VARIANT_FIXED);
  assign bus.addr = adr_r;
  assign bus.rd_wr_n = rd_r;
  assign bus.transfer_size = 2'h2;
  assign bus.ack_chip_select_n = !act_ack;
  assign bus.addr_strobe_n = !act_ack;
  assign bus.data_strobe_n = !(ds_r && act_ack);
  assign bus.upper_strobe_n = !(act_ack && be_r[1]);
  assign bus.lower_strobe_n = !(act_ack && be_r[0]);
  assign bus.fixed_chip_select_n = !act_fix;
  assign bus.high_byte_enable_n = !(act_fix && be_r[1]);
  assign bus.low_byte_enable_n = !(act_fix && be_r[0]);
  assign bus.output_enable_n = !(act_fix && rd_r);
  assign bus.host_data = wd_r; // [R8]
  assign bus.host_data_oe = sel_r && !rd_r;
  assign busy_out = (st_r != HBSV_H_IDLE);
  assign done_out = done_r;
  assign rdata_out = rd_dat_r;
endmodule : hbsv_host

// file: hbsv_pkg.sv
// Contract
// R1 - Acknowledge driven once select and address strobe low.
// R2 - Acknowledge driven high then released after strobe.
// R3 - Read data driven once data strobe asserted.
// R4 - Read data valid when acknowledge falls.
// R5 - Data bus released after data strobe rises.
// R6 - Host holds data strobe until acknowledge seen.
// R7 - Host idles control one clock between cycles.
// R8 - Host presents write data before fourth edge.
// R9 - Fixed variant captures write data fourth edge.
// R10 - Fixed read data valid by ratio-dependent bound.
// R11 - Fixed variant drives bus under enables, releases after.
// R12 - Fixed variant access lasts exactly ten clocks.
// R13 - Block-transfer functions unavailable in fixed variant.
// R14 - One variant selected at reset, other ignored.
package hbsv_pkg;
  localparam int HBSV_DATA_W = 16;
  localparam int HBSV_ADDR_W = 17;
  localparam logic [3:0] HBSV_WR_EDGE = 4'h4;
  localparam logic [3:0] HBSV_FIXED_LEN = 4'hA;
  localparam logic [3:0] HBSV_ACK_DELAY = 4'h3;
  localparam logic [3:0] HBSV_RD_LAT_DIV1 = 4'h5;
  localparam logic [3:0] HBSV_RD_LAT_DIV2 = 4'h8;
  localparam logic [3:0] HBSV_RD_LAT_DIV3 = 4'hA;
  localparam logic [3:0] HBSV_RD_LAT_DIV4 = 4'hD;
  localparam logic HBSV_VARIANT_ACK = 1'b0;
  localparam logic HBSV_VARIANT_FIXED = 1'b1;
endpackage : hbsv_pkg

// file: tb.sv
`timescale 1ns/1ns
// --------------------------------------------
// Testbench of host and device ends.
// --------------------------------------------
module tb;
  import hbsv_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic var_sel = 0;
  logic hv = 0;
  logic [16:0] exp_ra = 0;
  logic [15:0] dw;
  logic [15:0] dmem [int];
  logic req = 0;
  logic rd = 0;
  logic [1:0] div = 0;
  logic [1:0] be = 0;
  logic [16:0] addr = 0;
  logic [15:0] wd = 0;
  logic [15:0] rdd = 0;
  logic [3:0] lat = 0;
  logic busy, done, wv, rq, blt;
  logic [16:0] wa, ra;
  logic [15:0] wdo, rdata;
  logic [1:0] wbe;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] mem [int];
  logic [34:0] wq [$];
  hbsv_bus_if bus ();
  hbsv_host u_hbsv_host (.sys_clk_in(clk), .resetn_in(rstn), .variant_in(hv), .req_in(req), .req_rd_in(rd),
    .req_addr_in(addr), .req_wdata_in(wd), .req_be_in(be), .req_rd_lat_in(lat), .busy_out(busy),
    .done_out(done), .rdata_out(rdata), .bus(bus.host));
  hbsv_device u_hbsv_device (.sys_clk_in(clk), .resetn_in(rstn), .variant_sel_in(var_sel), .mclk_div_in(div),
    .bus(bus.device), .wr_valid_out(wv), .wr_addr_out(wa), .wr_data_out(wdo), .wr_be_out(wbe),
    .rd_req_out(rq), .rd_addr_out(ra), .rd_data_in(rdd), .blt_enable_out(blt));
  hbsv_bus_chk u_hbsv_bus_chk (.sys_clk_in(clk), .resetn_in(rstn), .rd_wr_n(bus.rd_wr_n),
    .addr_strobe_n(bus.addr_strobe_n), .data_strobe_n(bus.data_strobe_n),
    .ack_chip_select_n(bus.ack_chip_select_n), .fixed_chip_select_n(bus.fixed_chip_select_n),
    .output_enable_n(bus.output_enable_n), .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
    .port_size_ack_n(bus.port_size_ack_n), .port_size_ack_oe(bus.port_size_ack_oe));
  initial forever #5 clk = ~clk;
  task automatic complete_run();
    $display("comparisons %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [34:0] got, input logic [34:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic acc(input logic r, input logic [16:0] a, input logic [15:0] d, input logic [1:0] b,
    input logic x);
    logic [15:0] e;
    int n;
    e = mem.exists(a) ? mem[a] : 16'h0000;
    if (!r && !x)
    begin
      e = {b[1] ? d[15:8] : e[15:8], b[0] ? d[7:0] : e[7:0]};
      mem[a] = e;
      wq.push_back({a, b, d});
    end
    exp_ra = a;
    @(posedge clk);
    req <= 1'b1;
    hv <= x ? !var_sel : var_sel;
    rd <= r;
    addr <= a;
    wd <= d;
    be <= b;
    if (r)
      rdd <= dmem.exists(int'(a)) ? dmem[int'(a)] : 16'h0000;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (busy !== 1'b1 && n < 20);
    @(posedge clk);
    req <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 60);
    check(done, 1'b1, "done");
    if (r)
      check(rdata, e, "read data");
  endtask : acc
  task automatic run(input logic v, input logic [1:0] k);
    logic [16:0] a;
    @(posedge clk);
    rstn <= 1'b0;
    var_sel <= v;
    div <= k;
    lat <= k == 2'h0 ? HBSV_RD_LAT_DIV1 : k == 2'h1 ? HBSV_RD_LAT_DIV2 : k == 2'h2 ? HBSV_RD_LAT_DIV3 : HBSV_RD_LAT_DIV4;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(blt, !v, "blt enable");
    for (int i = 0; i < 4; i++)
    begin
      a = 17'($urandom) & 17'h1FFFE;
      acc(1'b0, a, 16'($urandom), 2'h3, 1'b0);
      acc(1'b0, a, 16'($urandom), 2'($urandom_range(1, 3)), 1'b0);
      acc(1'b1, a, 16'h0000, 2'h3, 1'b0);
    end
    if (v == HBSV_VARIANT_ACK)
    begin
      acc(1'b0, a, 16'($urandom), 2'h3, 1'b1);
      acc(1'b1, a, 16'h0000, 2'h3, 1'b0);
    end
  endtask : run
  always @(posedge clk)
  begin
    if (rstn && rq === 1'b1)
      check(35'(ra), 35'(exp_ra), "read address");
    if (rstn && wv === 1'b1)
    begin
      check({wa, wbe, wdo}, wq.size() > 0 ? wq.pop_front() : 35'h0, "write");
      dw = dmem.exists(int'(wa)) ? dmem[int'(wa)] : 16'h0000;
      dmem[int'(wa)] = {wbe[1] ? wdo[15:8] : dw[15:8], wbe[0] ? wdo[7:0] : dw[7:0]};
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(32'h7213));
    run(HBSV_VARIANT_ACK, 2'h0);
    for (int k = 0; k < 4; k++)
      run(HBSV_VARIANT_FIXED, 2'(k));
    complete_run();
  end
endmodule : tb
